// file: logic/pcs_core.sv
// Purpose: Program counter, return stack and indirect addressing
// Assumes: Decode logic issues one op per cycle on the same clock
// Notes: Stack pointer has no software view
//
// The implementer's own choices: the address map and strobed register access.
`timescale 1ns/100ps
module pcs_core
  import pcs_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire pcs_pkg::pcs_op_e op,
  input wire logic [pcs_pkg::JUMP_W-1:0] jumpAddr,
  input wire logic [pcs_pkg::PC_W-1:0] vectorAddr,
  input wire logic [pcs_pkg::DATA_W-1:0] lowByteWrData,
  input wire logic latchWrEn,
  input wire logic [pcs_pkg::DATA_W-1:0] latchWrData,
  input wire logic ptrWrEn,
  input wire logic [pcs_pkg::DATA_W-1:0] ptrWrData,
  input wire logic bankSelWrEn,
  input wire logic bankSelWrData,
  input wire logic indRdEn,
  input wire logic indWrEn,
  input wire logic [pcs_pkg::DATA_W-1:0] indWrData,
  input wire logic [pcs_pkg::DATA_W-1:0] memRdData,
  output logic [pcs_pkg::PC_W-1:0] pc,
  output logic [pcs_pkg::DATA_W-1:0] pcLowByte,
  output logic [pcs_pkg::DATA_W-1:0] latchRd,
  output logic [pcs_pkg::DATA_W-1:0] ptrRd,
  output logic [pcs_pkg::DADDR_W-1:0] memAddr,
  output logic memRdEn,
  output logic memWrEn,
  output logic [pcs_pkg::DATA_W-1:0] memWrData,
  output logic [pcs_pkg::DATA_W-1:0] indRdData
);
  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  logic [PC_W-1:0] pc_q, pc_d;
  logic [DATA_W-1:0] latch_q, latch_d;
  logic [DATA_W-1:0] ptr_q, ptr_d;
  logic bank_q, bank_d;
  logic [SP_W-1:0] sp_q, sp_d;
  logic [DADDR_W-1:0] memAddr_q, memAddr_d;
  logic memRdEn_q, memRdEn_d, memWrEn_q, memWrEn_d;
  logic [DATA_W-1:0] memWrData_q, memWrData_d;
  logic [DATA_W-1:0] indRd_q, indRd_d;
  logic pendRd_q, pendRd_d, pendSelf_q, pendSelf_d;
  logic [PC_W-1:0] stackQ [DEPTH];
  logic [DEPTH-1:0] entryWr;
  logic [PC_W-1:0] pushVal;
  logic [SP_W-1:0] popIdx;
  logic [DADDR_W-1:0] effAddr;
  logic selfRef;
  logic [DATA_W-1:0] indRdMux;

  // ------------------------------------------------------------
  // Return stack storage
  // ------------------------------------------------------------
  for (genvar i = 0; i < DEPTH; i++) begin : gEntry
    pcs_stack_entry #(.W(PC_W)) uEntry (
      .clk(clk),
      .rst(rst),
      .wrEn(entryWr[i]),
      .wrData(pushVal),
      .q(stackQ[i])
    );
  end

  // ------------------------------------------------------------
  // Indirect addressing
  // ------------------------------------------------------------
  pcs_indirect uInd (
    .bankSel(bank_q),
    .pointer(ptr_q),
    .memRdData(memRdData),
    .effAddr(effAddr),
    .selfRef(selfRef),
    .rdData(indRdMux)
  );

  // ------------------------------------------------------------
  // Program counter and stack control
  // ------------------------------------------------------------
  always_comb begin
    pc_d = pc_q;
    sp_d = sp_q;
    entryWr = '0;
    pushVal = pc_q;
    popIdx = sp_q - 3'h1;
    case (op)
      PCS_OP_STEP: begin
        pc_d = pc_q + 13'h0001;
      end
      PCS_OP_JUMP: begin
        pc_d = {latch_q[LATCH_FULL_HI:LATCH_JUMP_LO], jumpAddr};
      end
      PCS_OP_CALL: begin
        entryWr[sp_q] = 1'b1;
        sp_d = sp_q + 3'h1;
        pc_d = {latch_q[LATCH_FULL_HI:LATCH_JUMP_LO], jumpAddr};
      end
      PCS_OP_VECTOR: begin
        entryWr[sp_q] = 1'b1;
        sp_d = sp_q + 3'h1;
        pc_d = vectorAddr;
      end
      PCS_OP_RET: begin
        pc_d = stackQ[popIdx];
        sp_d = popIdx;
      end
      PCS_OP_LOWWR: begin
        pc_d = {latch_q[LATCH_FULL_HI:0], lowByteWrData};
      end
      default: begin
        pc_d = pc_q;
      end
    endcase
  end

  // Latch and pointer only change on their own writes
  always_comb begin
    latch_d = latchWrEn ? latchWrData : latch_q;
    ptr_d = ptrWrEn ? ptrWrData : ptr_q;
    bank_d = bankSelWrEn ? bankSelWrData : bank_q;
  end

  // ------------------------------------------------------------
  // Indirect access requests
  // ------------------------------------------------------------
  always_comb begin
    memAddr_d = effAddr;
    memRdEn_d = indRdEn & ~selfRef;
    memWrEn_d = indWrEn & ~selfRef;
    memWrData_d = indWrData;
    pendRd_d = indRdEn;
    pendSelf_d = selfRef;
    indRd_d = indRd_q;
    if (pendRd_q) begin
      indRd_d = pendSelf_q ? ZERO_BYTE : memRdData;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pc_q <= PC_RESET;
      sp_q <= SP_RESET;
      latch_q <= LATCH_RESET;
      ptr_q <= PTR_RESET;
      bank_q <= 1'b0;
      memAddr_q <= '0;
      memRdEn_q <= 1'b0;
      memWrEn_q <= 1'b0;
      memWrData_q <= '0;
      indRd_q <= '0;
      pendRd_q <= 1'b0;
      pendSelf_q <= 1'b0;
    end else begin
      pc_q <= pc_d;
      sp_q <= sp_d;
      latch_q <= latch_d;
      ptr_q <= ptr_d;
      bank_q <= bank_d;
      memAddr_q <= memAddr_d;
      memRdEn_q <= memRdEn_d;
      memWrEn_q <= memWrEn_d;
      memWrData_q <= memWrData_d;
      indRd_q <= indRd_d;
      pendRd_q <= pendRd_d;
      pendSelf_q <= pendSelf_d;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign pc = pc_q;
  assign pcLowByte = pc_q[DATA_W-1:0];
  assign latchRd = latch_q;
  assign ptrRd = ptr_q;
  assign memAddr = memAddr_q;
  assign memRdEn = memRdEn_q;
  assign memWrEn = memWrEn_q;
  assign memWrData = memWrData_q;
  assign indRdData = indRd_q;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  sequence s_call;
    op == PCS_OP_CALL;
  endsequence
  sequence s_ret;
    op == PCS_OP_RET;
  endsequence

  AST_RESET_PC: assert property (@(posedge clk)
    rst |=> pc == 13'h0000) else $error("pc not cleared by reset");
  AST_LOWWR_LOAD: assert property (@(posedge clk) disable iff (rst)
    op == PCS_OP_LOWWR |=> pc == {$past(latch_q[4:0]), $past(lowByteWrData)})
    else $error("low byte write load wrong");
  AST_JUMP_LOAD: assert property (@(posedge clk) disable iff (rst)
    op == PCS_OP_JUMP |=> pc == {$past(latch_q[4:3]), $past(jumpAddr)})
    else $error("jump load wrong");
  AST_CALL_RET: assert property (@(posedge clk) disable iff (rst)
    s_call ##1 s_ret |=> pc == $past(pc, 2))
    else $error("return address mismatch");
  AST_PUSH_SP: assert property (@(posedge clk) disable iff (rst)
    s_call |=> sp_q == $past(sp_q) + 3'h1) else $error("push pointer");
  AST_LATCH_KEEP: assert property (@(posedge clk) disable iff (rst)
    (op == PCS_OP_CALL || op == PCS_OP_RET) && !latchWrEn
      |=> $stable(latch_q))
    else $error("latch changed by stack op");
  AST_SELF_WRITE: assert property (@(posedge clk) disable iff (rst)
    indWrEn && selfRef |=> !memWrEn) else $error("self write stored");
  AST_SELF_READ: assert property (@(posedge clk) disable iff (rst)
    indRdEn && selfRef |=> ##1 indRdData == 8'h00)
    else $error("self read not zero");
  AST_EFF_ADDR: assert property (@(posedge clk) disable iff (rst)
    indRdEn && !selfRef |=> memAddr == {$past(bank_q), $past(ptr_q)})
    else $error("indirect address wrong");
endmodule : pcs_core

// file: logic/pcs_pkg.sv
// Purpose: Constants for program counter, return stack and indirect addressing
// Assumes: One core clock, synchronous active-high reset
// Notes: How it works list below
// How it works
// - Program counter is one 13-bit register.
// - Low counter byte is readable and writable by software.
// - Upper counter bits are never read or written directly; latch feeds them.
// - Any reset clears the whole program counter.
// - Writing the low byte loads upper bits from latch bits 4..0.
// - Jumps and subroutine jumps take top two bits from latch bits 4..3.
// - Return stack holds eight entries of thirteen bits.
// - Stack and its pointer are invisible to software.
// - Subroutine jump or interrupt vectoring pushes the program counter.
// - Subroutine exit, exit with literal, interrupt exit pop the stack.
// - Push and pop leave the upper holding latch untouched.
// - Stack is circular; ninth push overwrites the first.
// - No overflow or underflow status exists.
// - Indirect port has no storage; it reaches the pointed location.
// - Indirect read pointing at the port itself returns zero.
// - Indirect write pointing at the port itself stores nothing.
// - Indirect address is bank select bit above the 8-bit pointer.
// - Bank select set picks banks 2 and 3, clear picks 0 and 1.
package pcs_pkg;
  localparam int PC_W = 13;
  localparam int JUMP_W = 11;
  localparam int DEPTH = 8;
  localparam int SP_W = 3;
  localparam int DATA_W = 8;
  localparam int DADDR_W = 9;
  localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
  localparam logic [SP_W-1:0] SP_RESET = 3'h0;
  localparam logic [DATA_W-1:0] LATCH_RESET = 8'h00;
  localparam logic [DATA_W-1:0] PTR_RESET = 8'h00;
  // Data-space location of the indirect access port (low 7 bits)
  localparam logic [6:0] INDIRECT_PORT_LOC = 7'h00;
  localparam int LATCH_FULL_HI = 4;
  localparam int LATCH_JUMP_LO = 3;
  localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
  typedef enum logic [2:0] {
    PCS_OP_NONE, PCS_OP_STEP, PCS_OP_JUMP, PCS_OP_CALL,
    PCS_OP_RET, PCS_OP_VECTOR, PCS_OP_LOWWR
  } pcs_op_e;
endpackage : pcs_pkg

// file: logic/pcs_stack_entry.sv
// Purpose: One 13-bit return-stack entry
// Assumes: Write enable from the stack control
// Notes: None
`timescale 1ns/100ps
module pcs_stack_entry #(
  parameter int W = 13
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic wrEn,
  input wire logic [W-1:0] wrData,
  output logic [W-1:0] q
);
  logic [W-1:0] entry_d;
  logic [W-1:0] entry_q;
  always_comb begin
    entry_d = entry_q;
    if (wrEn) begin
      entry_d = wrData;
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      entry_q <= '0;
    end else begin
      entry_q <= entry_d;
    end
  end
  assign q = entry_q;
endmodule : pcs_stack_entry

// file: logic/pcs_indirect.sv
// Purpose: Indirect address formation and self-reference guard
// Assumes: Pointer and bank select registered in the top
// Notes: Pure combinational
`timescale 1ns/100ps
module pcs_indirect
  import pcs_pkg::*;
(
  input wire logic bankSel,
  input wire logic [DATA_W-1:0] pointer,
  input wire logic [DATA_W-1:0] memRdData,
  output logic [DADDR_W-1:0] effAddr,
  output logic selfRef,
  output logic [DATA_W-1:0] rdData
);
  always_comb begin
    effAddr = {bankSel, pointer};
    selfRef = (pointer[6:0] == INDIRECT_PORT_LOC);
    rdData = selfRef ? ZERO_BYTE : memRdData;
  end
endmodule : pcs_indirect

// file: dv/pcs_mem_model.sv
// Purpose: Data memory behind the indirect access port
// Assumes: Read data valid in the strobe cycle and the one after
// Notes: Outside that window the read data show a changing pattern
`timescale 1ns/100ps
module pcs_mem_model
  import pcs_pkg::*;
(
  input wire logic clk,
  input wire logic [pcs_pkg::DADDR_W-1:0] memAddr,
  input wire logic memRdEn,
  input wire logic memWrEn,
  input wire logic [pcs_pkg::DATA_W-1:0] memWrData,
  output logic [pcs_pkg::DATA_W-1:0] memRdData
);
  logic [DATA_W-1:0] mem [512];
  logic [DATA_W-1:0] rdQ = 8'h00;
  logic holdQ = 1'b0;
  always @(posedge clk) begin
    if (memWrEn) mem[memAddr] <= memWrData;
    if (memRdEn) rdQ <= mem[memAddr];
    else rdQ <= ~rdQ;
    holdQ <= memRdEn;
  end
  assign memRdData = memRdEn ? mem[memAddr] : (holdQ ? rdQ : ~rdQ);
endmodule : pcs_mem_model

// file: dv/program_counter_stack_indirect_test.sv
// Purpose: Self-checking bench for the counter, stack and indirect port
// Assumes: One op per request, results one cycle later, indirect read data two cycles later
// Notes: Integer model with circular stack and memory image
`timescale 1ns/100ps
module program_counter_stack_indirect_test;
  import pcs_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  pcs_op_e op = PCS_OP_NONE;
  logic [10:0] jumpAddr = 11'h000;
  logic [12:0] vectorAddr = 13'h0000, pc;
  logic [7:0] lowByteWrData = 8'h00, latchWrData = 8'h00, ptrWrData = 8'h00;
  logic [7:0] indWrData = 8'h00, memRdData, pcLowByte, latchRd, ptrRd;
  logic [7:0] memWrData, indRdData, rnd = 8'h22;
  logic latchWrEn = 1'b0, ptrWrEn = 1'b0, bankSelWrEn = 1'b0;
  logic bankSelWrData = 1'b0, indRdEn = 1'b0, indWrEn = 1'b0;
  logic memRdEn, memWrEn;
  logic [8:0] memAddr;
  int error_cnt = 0, samples_checked = 0;
  int ePc = 0, eLatch = 0, ePtr = 0, eBank = 0, eSp = 0;
  int eStack[8] = '{default: 0};
  int eMem[512];
  int ptab[4] = '{8'h00, 8'h21, 8'h80, 8'hFF};
  always #5 clk = ~clk;
  pcs_core pcs_core_inst (.clk(clk), .rst(rst), .op(op),
    .jumpAddr(jumpAddr), .vectorAddr(vectorAddr),
    .lowByteWrData(lowByteWrData), .latchWrEn(latchWrEn),
    .latchWrData(latchWrData), .ptrWrEn(ptrWrEn), .ptrWrData(ptrWrData),
    .bankSelWrEn(bankSelWrEn), .bankSelWrData(bankSelWrData),
    .indRdEn(indRdEn), .indWrEn(indWrEn), .indWrData(indWrData),
    .memRdData(memRdData), .pc(pc), .pcLowByte(pcLowByte),
    .latchRd(latchRd), .ptrRd(ptrRd), .memAddr(memAddr),
    .memRdEn(memRdEn), .memWrEn(memWrEn), .memWrData(memWrData),
    .indRdData(indRdData));
  pcs_mem_model pcs_mem_model_inst (.clk(clk), .memAddr(memAddr),
    .memRdEn(memRdEn), .memWrEn(memWrEn), .memWrData(memWrData),
    .memRdData(memRdData));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr
  task automatic check(input logic [15:0] got, exp, input string msg);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : check
  task automatic final_report;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : final_report
  task automatic doOp(input pcs_op_e o, input int a);
    @(posedge clk);
    op <= o;
    jumpAddr <= a[10:0];
    vectorAddr <= a[12:0];
    lowByteWrData <= a[7:0];
    @(posedge clk);
    op <= PCS_OP_NONE;
    if (o == PCS_OP_CALL || o == PCS_OP_VECTOR) begin
      eStack[eSp] = ePc;
      eSp = (eSp + 1) % 8;
    end
    case (o)
      PCS_OP_STEP: ePc = (ePc + 1) & 16'h1FFF;
      PCS_OP_JUMP, PCS_OP_CALL: ePc = (eLatch & 8'h18) << 8 | a & 16'h7FF;
      PCS_OP_LOWWR: ePc = (eLatch & 8'h1F) << 8 | a & 8'hFF;
      PCS_OP_VECTOR: ePc = a & 16'h1FFF;
      PCS_OP_RET: begin
        eSp = (eSp + 7) % 8;
        ePc = eStack[eSp];
      end
      default: ;
    endcase
    #1;
    check(pc, ePc[15:0], "pc");
    check(pcLowByte, ePc[7:0], "low byte");
    check(latchRd, eLatch[15:0], "latch");
  endtask : doOp
  // Call and return on consecutive edges, no idle cycle between
  task automatic callRet(input int a);
    int keep;
    keep = ePc;
    @(posedge clk);
    op <= PCS_OP_CALL;
    jumpAddr <= a[10:0];
    @(posedge clk);
    op <= PCS_OP_RET;
    eStack[eSp] = ePc;
    ePc = (eLatch & 8'h18) << 8 | a & 16'h7FF;
    #1;
    check(pc, ePc[15:0], "call target");
    @(posedge clk);
    op <= PCS_OP_NONE;
    ePc = keep;
    #1;
    check(pc, ePc[15:0], "back to back return");
    check(latchRd, eLatch[15:0], "latch after return");
  endtask : callRet
  task automatic setRegs(input int l, p, b);
    @(posedge clk);
    latchWrEn <= 1'b1;
    latchWrData <= l[7:0];
    ptrWrEn <= 1'b1;
    ptrWrData <= p[7:0];
    bankSelWrEn <= 1'b1;
    bankSelWrData <= b[0];
    @(posedge clk);
    {latchWrEn, ptrWrEn, bankSelWrEn} <= 3'h0;
    {eLatch, ePtr, eBank} = {l & 255, p & 255, b & 1};
    #1;
    check(ptrRd, ePtr[15:0], "pointer");
  endtask : setRegs
  task automatic indAcc(input bit wr, input int d);
    int self;
    int addr;
    self = (ePtr & 8'h7F) == 0;
    addr = eBank * 256 + ePtr;
    @(posedge clk);
    if (wr) indWrData <= d[7:0];
    if (wr) indWrEn <= 1'b1;
    else indRdEn <= 1'b1;
    @(posedge clk);
    {indWrEn, indRdEn} <= 2'h0;
    #1;
    check(wr ? memWrEn : memRdEn, !self, "strobe");
    if (!self) check(memAddr, addr[15:0], "address");
    if (wr && !self) check(memWrData, d[7:0], "wr data");
    if (wr && !self) eMem[addr] = d & 255;
    if (!wr) repeat (1) @(posedge clk);
    #1;
    if (!wr) check(indRdData, self ? 0 : eMem[addr], "rd data");
  endtask : indAcc
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    #1;
    check(pc, 16'h0000, "pc reset");
    for (int i = 0; i < 8; i++) begin
      rnd = lfsr(rnd);
      setRegs(rnd, 0, 0);
      rnd = lfsr(rnd);
      doOp(PCS_OP_LOWWR, rnd & 8'hF0);
      doOp(PCS_OP_STEP, 0);
      rnd = lfsr(rnd);
      doOp(PCS_OP_JUMP, rnd << 3 | i);
    end
    $display("jump and low byte test done");
    for (int i = 0; i < 9; i++) doOp(PCS_OP_CALL, i * 131 + 5);
    doOp(PCS_OP_VECTOR, 16'h1ABC);
    for (int i = 0; i < 11; i++) doOp(PCS_OP_RET, 0);
    callRet(16'h0555);
    rnd = lfsr(rnd);
    callRet(rnd << 3);
    $display("stack test done");
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    ePc = 0;
    eLatch = 0;
    ePtr = 0;
    eBank = 0;
    eSp = 0;
    eStack = '{default: 0};
    #1;
    check(pc, 16'h0000, "pc mid reset");
    check(latchRd, 16'h0000, "latch mid reset");
    check(ptrRd, 16'h0000, "pointer mid reset");
    doOp(PCS_OP_RET, 0);
    $display("reset test done");
    for (int k = 0; k < 8; k++) begin
      rnd = lfsr(rnd);
      setRegs(eLatch, ptab[k % 4], k / 4);
      indAcc(1'b1, rnd);
    end
    for (int k = 0; k < 8; k++) begin
      setRegs(eLatch, ptab[k % 4], k / 4);
      indAcc(1'b0, 0);
    end
    $display("indirect test done");
    final_report();
  end
  initial begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    $display("mismatch at %0t: run timeout", $time);
    final_report();
  end
endmodule : program_counter_stack_indirect_test
